// >>> rtl/shcs_consts.svh
// timing and layout constants for the sample/hold convert sequencer
`ifndef SHCS_CONSTS_SVH
`define SHCS_CONSTS_SVH
`define SHCS_CLK_PERIOD_NS   20
`define SHCS_APERTURE_NS     20
`define SHCS_CONV12_US       18
`define SHCS_CONV8_US        12
`define SHCS_ACQ_US          4
`define SHCS_THRU12_MAX_US   25
`define SHCS_THRU8_MAX_US    18
`define SHCS_APERTURE_CYC    ((`SHCS_APERTURE_NS + `SHCS_CLK_PERIOD_NS - 1) / `SHCS_CLK_PERIOD_NS)
`define SHCS_CONV12_CYC      ((`SHCS_CONV12_US * 1000) / `SHCS_CLK_PERIOD_NS)
`define SHCS_CONV8_CYC       ((`SHCS_CONV8_US * 1000) / `SHCS_CLK_PERIOD_NS)
`define SHCS_ACQ_CYC         ((`SHCS_ACQ_US * 1000) / `SHCS_CLK_PERIOD_NS)
`define SHCS_RES_W           12
`define SHCS_BYTE8_LSB       4
`endif

// >>> rtl/shcs_pkg.sv
// types for the sample/hold convert sequencer
package shcs_pkg;
    typedef enum logic [3:0] {
        ST_TRACK = 4'h1,
        ST_APER  = 4'h2,
        ST_CONV  = 4'h4,
        ST_ACQ   = 4'h8
    } shcs_state_t;

    typedef struct packed {
        logic chip_en;
        logic chip_sel_n;
        logic read_conv_n;
        logic data_mode_12;
        logic byte_select_short_cycle;
    } shcs_ctrl_t;
endpackage

// >>> rtl/shcs_result_reg.sv
// result holding register with registered read data
`timescale 1ns/1ps
module shcs_result_reg #(
    parameter int WIDTH = 12
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             wr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic      [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;

    // capture on write
    always_comb begin
        data_next = wr_in ? wdata_in : data_reg;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_reg <= '0;
        end else begin
            data_reg <= data_next;
        end
    end

    assign rdata_out = data_reg;
endmodule

// >>> rtl/shcs_sequencer.sv
// sample/hold control mode convert sequencer, top level
// What this block does
// - one convert command holds and starts conversion
// - conversion end releases hold to tracking
// - conversion lasts 18 us or 12 us
// - throughput within 25 us or 18 us
// - sample taken 20 ns after command
// - result bit 11 is msb, 0 lsb
// - last of three conditions starts conversion
// - flag high only while converting, no restart
// - latch short-cycle input at start
// - outputs float unless read conditions met
`timescale 1ns/1ps
`include "shcs_consts.svh"
module shcs_sequencer #(
    parameter int CONV12_CYC = `SHCS_CONV12_CYC,
    parameter int CONV8_CYC  = `SHCS_CONV8_CYC,
    parameter int ACQ_CYC    = `SHCS_ACQ_CYC
) (
    input  wire logic                   CLK_SYS_IN,
    input  wire logic                   RESETN_IN,
    input  wire logic                   CHIP_EN_IN,
    input  wire logic                   CHIP_SEL_N_IN,
    input  wire logic                   READ_CONV_N_IN,
    input  wire logic                   DATA_MODE_12_IN,
    input  wire logic                   BYTE_SELECT_SHORT_CYCLE_IN,
    input  wire logic [`SHCS_RES_W-1:0] CODE_IN,
    output logic                        CONVERSION_FLAG_OUT,
    output logic                        HOLD_OUT,
    output logic                        ACQ_BUSY_OUT,
    output logic                        SHORT_CYCLE_OUT,
    output logic [`SHCS_RES_W-1:0]      RESULT_LINES_OUT,
    output logic [`SHCS_RES_W-1:0]      RESULT_LINES_OE_N_OUT
);
    // control pins gathered as one bundle
    shcs_pkg::shcs_ctrl_t  ctrl;
    shcs_pkg::shcs_state_t state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic        start_ok_reg, start_ok_next;
    logic        short_reg, short_next;
    logic        flag_reg, flag_next;
    logic        hold_reg, hold_next;
    logic        acq_reg, acq_next;
    logic        start_cond, start_evt, conv_done;
    logic [`SHCS_RES_W-1:0] result_q;
    logic [`SHCS_RES_W-1:0] samp_reg, samp_next;
    logic [`SHCS_RES_W-1:0] out_reg, out_next;
    logic [`SHCS_RES_W-1:0] oen_reg, oen_next;

    // cycles of conversion for the latched length; the aperture cycle
    // is part of it, so the flag spans exactly this many cycles
    function automatic logic [15:0] conv_len(input logic short_cyc);
        conv_len = short_cyc ? 16'(CONV8_CYC) : 16'(CONV12_CYC);
    endfunction

    // left-justified upper byte with the low nibble forced to zero
    function automatic logic [`SHCS_RES_W-1:0] msb_byte(input logic [`SHCS_RES_W-1:0] code);
        msb_byte = {code[`SHCS_RES_W-1:`SHCS_BYTE8_LSB], 4'h0};
    endfunction

    assign ctrl = '{CHIP_EN_IN, CHIP_SEL_N_IN, READ_CONV_N_IN, DATA_MODE_12_IN,
                    BYTE_SELECT_SHORT_CYCLE_IN};
    // start is the rising edge of the three-way condition: whichever of
    // enable, select or read/convert arrives last fires it; a condition
    // that was already true at reset release must drop first, and while
    // the flag is high a fresh edge is ignored
    assign start_cond = ctrl.chip_en & ~ctrl.chip_sel_n & ~ctrl.read_conv_n;
    assign start_evt  = start_cond & ~start_ok_reg & ~flag_reg;
    assign conv_done  = (state_reg == shcs_pkg::ST_CONV) && (cnt_reg == 16'h0001);

    // result store: the held sample becomes the result as the last cycle
    // ends, so a read never sees a half-built code
    shcs_result_reg #(.WIDTH(`SHCS_RES_W)) u_result (
        .clk_in    (CLK_SYS_IN),
        .resetn_in (RESETN_IN),
        .wr_in     (conv_done),
        .wdata_in  (short_reg ? msb_byte(samp_reg) : samp_reg),
        .rdata_out (result_q)
    );

    // sequencer next state
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        short_next    = short_reg;
        flag_next     = flag_reg;
        hold_next     = hold_reg;
        acq_next      = acq_reg;
        start_ok_next = start_cond;
        case (state_reg)
            shcs_pkg::ST_TRACK, shcs_pkg::ST_ACQ: begin
                if (state_reg == shcs_pkg::ST_ACQ) begin
                    cnt_next = cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0001) begin
                        state_next = shcs_pkg::ST_TRACK;
                        acq_next   = 1'b0;
                    end
                end
                // a start during acquisition is taken; keeping that window
                // clear is the controller's duty
                if (start_evt) begin
                    short_next = ctrl.byte_select_short_cycle;
                    flag_next  = 1'b1;
                    acq_next   = 1'b0;
                    state_next = shcs_pkg::ST_APER;
                    cnt_next   = 16'(`SHCS_APERTURE_CYC);
                end
            end
            // aperture: one cycle from command to hold
            shcs_pkg::ST_APER: begin
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0001) begin
                    hold_next  = 1'b1;
                    state_next = shcs_pkg::ST_CONV;
                    cnt_next   = conv_len(short_reg) - 16'(`SHCS_APERTURE_CYC);
                end
            end
            // conversion: count down, release hold on the last cycle
            shcs_pkg::ST_CONV: begin
                cnt_next = cnt_reg - 16'h0001;
                if (conv_done) begin
                    hold_next  = 1'b0;
                    flag_next  = 1'b0;
                    acq_next   = 1'b1;
                    state_next = shcs_pkg::ST_ACQ;
                    cnt_next   = 16'(ACQ_CYC);
                end
            end
            // unreachable codes fall back to tracking
            default: begin
                state_next = shcs_pkg::ST_TRACK;
                cnt_next   = 16'h0000;
                flag_next  = 1'b0;
                hold_next  = 1'b0;
                acq_next   = 1'b0;
            end
        endcase
    end

    // sequencer registers; the start detector resets high so that a
    // convert condition already true at reset release is not taken
    // as a start, and the controller must first release it
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_reg    <= shcs_pkg::ST_TRACK;
            cnt_reg      <= 16'h0000;
            start_ok_reg <= 1'b1;
            short_reg    <= 1'b0;
            flag_reg     <= 1'b0;
            hold_reg     <= 1'b0;
            acq_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            start_ok_reg <= start_ok_next;
            short_reg    <= short_next;
            flag_reg     <= flag_next;
            hold_reg     <= hold_next;
            acq_reg      <= acq_next;
        end
    end

    // held sample: the code is frozen on the edge that ends the aperture,
    // together with the switch to hold, so the controller may move the
    // input one cycle after its command without disturbing the result that
    // is being built
    always_comb begin
        samp_next = samp_reg;
        if (state_reg == shcs_pkg::ST_APER && cnt_reg == 16'h0001) begin
            samp_next = CODE_IN;
        end
    end

    // held sample register
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            samp_reg <= 12'h000;
        end else begin
            samp_reg <= samp_next;
        end
    end

    // output buffer enables and data formatting; the next flag value is
    // used so that the buffers let go on the same edge that a conversion
    // starts, and the lines never drive while the flag is high
    // byte mode: low select gives the upper byte, high the low nibble
    always_comb begin
        out_next = 12'h000;
        oen_next = 12'hFFF;
        if (ctrl.chip_en && !ctrl.chip_sel_n && ctrl.read_conv_n && !flag_next) begin
            if (ctrl.data_mode_12) begin
                out_next = result_q;
                oen_next = 12'h000;
            end else if (!ctrl.byte_select_short_cycle) begin
                out_next = msb_byte(result_q);
                oen_next = 12'h00F;
            end else begin
                out_next = {4'h0, 4'h0, result_q[3:0]};
                oen_next = 12'hF00;
            end
        end
    end

    // output registers: data and per-line enables
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            out_reg <= 12'h000;
            oen_reg <= 12'hFFF;
        end else begin
            out_reg <= out_next;
            oen_reg <= oen_next;
        end
    end

    // every output is a register, never a gate
    assign CONVERSION_FLAG_OUT   = flag_reg;
    assign HOLD_OUT              = hold_reg;
    assign ACQ_BUSY_OUT          = acq_reg;
    assign SHORT_CYCLE_OUT       = short_reg;
    assign RESULT_LINES_OUT      = out_reg;
    assign RESULT_LINES_OE_N_OUT = oen_reg;
endmodule

// >>> test/shcs_sva.sv
// port checks for the convert sequencer
`timescale 1ns/1ps
module shcs_sva #(
    parameter int CONV12_CYC = 900,
    parameter int CONV8_CYC  = 600
) (
    input wire logic        CLK_SYS_IN,
    input wire logic        RESETN_IN,
    input wire logic        CHIP_EN_IN,
    input wire logic        CHIP_SEL_N_IN,
    input wire logic        READ_CONV_N_IN,
    input wire logic        BYTE_SELECT_SHORT_CYCLE_IN,
    input wire logic        CONVERSION_FLAG_OUT,
    input wire logic        HOLD_OUT,
    input wire logic        ACQ_BUSY_OUT,
    input wire logic        SHORT_CYCLE_OUT,
    input wire logic [11:0] RESULT_LINES_OE_N_OUT
);
    int   cnt_reg, cnt_next;
    logic arm_reg, arm_next;
    wire  cv = CHIP_EN_IN && !CHIP_SEL_N_IN && !READ_CONV_N_IN;
    wire  rd = CHIP_EN_IN && !CHIP_SEL_N_IN && READ_CONV_N_IN;
    wire  go = cv && !arm_reg && !CONVERSION_FLAG_OUT;
    // busy length counter and previous start condition
    always_comb begin
        cnt_next = CONVERSION_FLAG_OUT ? cnt_reg + 1 : 0;
        arm_next = cv;
    end
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cnt_reg <= 0;
            arm_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            arm_reg <= arm_next;
        end
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);
    start_flag_a: assert property (go |=> CONVERSION_FLAG_OUT)
        else $error("start not taken");
    hold_follow_a: assert property ($rose(CONVERSION_FLAG_OUT) |=> HOLD_OUT)
        else $error("hold late");
    hold_inside_a: assert property (HOLD_OUT |-> CONVERSION_FLAG_OUT)
        else $error("hold outside conversion");
    short_latch_a: assert property (go |=> SHORT_CYCLE_OUT == $past(BYTE_SELECT_SHORT_CYCLE_IN))
        else $error("short cycle not latched");
    hold_release_a: assert property ($fell(CONVERSION_FLAG_OUT) |-> !HOLD_OUT && ACQ_BUSY_OUT)
        else $error("hold not released");
    busy_float_a: assert property (CONVERSION_FLAG_OUT |-> &RESULT_LINES_OE_N_OUT)
        else $error("driving while busy");
    idle_float_a: assert property (!rd |=> &RESULT_LINES_OE_N_OUT)
        else $error("driving without read");
    len_twelve_a: assert property ($fell(CONVERSION_FLAG_OUT) && !SHORT_CYCLE_OUT
        |-> cnt_reg >= CONV12_CYC - 1 && cnt_reg <= CONV12_CYC + 1)
        else $error("12-bit length wrong");
    len_eight_a: assert property ($fell(CONVERSION_FLAG_OUT) && SHORT_CYCLE_OUT
        |-> cnt_reg >= CONV8_CYC - 1 && cnt_reg <= CONV8_CYC + 1)
        else $error("8-bit length wrong");
    cover property ($fell(CONVERSION_FLAG_OUT) && SHORT_CYCLE_OUT);
    cover property ($fell(CONVERSION_FLAG_OUT) && !SHORT_CYCLE_OUT);
    cover property (rd && !CONVERSION_FLAG_OUT);
endmodule

// >>> test/shcs_host.sv
// controller model driving the converter's control pins and input code
`timescale 1ns/1ps
module shcs_host (
    input  wire logic           clk_in,
    output shcs_pkg::shcs_ctrl_t ct_out,
    output logic [11:0]          code_out
);
    // idle: deselected, read/convert high
    initial begin
        ct_out = 5'h1E;
        code_out = 12'h000;
    end
    // convert command, then deselect
    task automatic conv(input logic ao, input logic [11:0] code);
        @(posedge clk_in);
        ct_out <= '{1'b1, 1'b0, 1'b0, 1'b1, ao};
        code_out <= code;
        repeat (3) @(posedge clk_in);
        ct_out <= 5'h1E;
        code_out <= ~code;
    endtask
    // read access held for two edges
    task automatic rd(input logic m, input logic ao);
        @(posedge clk_in);
        ct_out <= '{1'b1, 1'b0, 1'b1, m, ao};
        repeat (2) @(posedge clk_in);
    endtask
endmodule

// >>> test/shcs_sequencer_bench.sv
// self-checking bench for the convert sequencer
`timescale 1ns/1ps
module shcs_sequencer_bench;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 flag, hold, acq, sc;
    logic [11:0]          res, oe_n, code, cd, er;
    shcs_pkg::shcs_ctrl_t ct;
    logic [11:0]          exp_q[$];
    int                   error_cnt = 0, n_tests = 0, n;
    time                  t0, t1, ta;
    initial begin
        forever #10 clk = ~clk;
    end
    // edge times of the busy flag and acquisition window
    always @(posedge flag) t0 = $time;
    always @(negedge flag) t1 = $time;
    always @(negedge acq) ta = $time;
    shcs_host u_host (.clk_in(clk), .ct_out(ct), .code_out(code));
    shcs_sequencer #(.CONV12_CYC(20), .CONV8_CYC(12), .ACQ_CYC(4)) u_dut (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CHIP_EN_IN(ct.chip_en),
        .CHIP_SEL_N_IN(ct.chip_sel_n), .READ_CONV_N_IN(ct.read_conv_n),
        .DATA_MODE_12_IN(ct.data_mode_12), .CODE_IN(code),
        .BYTE_SELECT_SHORT_CYCLE_IN(ct.byte_select_short_cycle),
        .CONVERSION_FLAG_OUT(flag), .HOLD_OUT(hold), .ACQ_BUSY_OUT(acq),
        .SHORT_CYCLE_OUT(sc), .RESULT_LINES_OUT(res), .RESULT_LINES_OE_N_OUT(oe_n));
    task automatic end_of_test();
        $display("tests=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp_v);
        n_tests++;
        if (got !== exp_v) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
        end
    endtask
    // bounded wait for flag (s=0) or acquisition (s=1) to reach v
    task automatic wt(input int s, input logic v);
        for (int k = 0; (s ? acq : flag) !== v; k++) begin
            if (k > 100) begin
                error_cnt++;
                end_of_test();
            end
            @(posedge clk);
            #1;
        end
    endtask
    initial begin
        void'($urandom(32'hA1A1933E));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({flag, hold, acq, oe_n}, 20'h00FFF);
        for (int i = 0; i < 4; i++) begin
            cd = 12'($urandom);
            u_host.conv(i[0], cd);
            exp_q.push_back(i[0] ? {cd[11:4], 4'h0} : cd);
            #1 chk({sc, hold, flag}, {i[0], 2'b11});
            if (i == 2) begin
                u_host.rd(1'b1, 1'b0);
                #1 chk(oe_n, 12'hFFF);
                u_host.conv(1'b1, cd);
                #1 chk(sc, 1'b0);
            end
            wt(0, 1'b0);
            chk({hold, acq}, 2'b01);
            n = int'((t1 - t0) / 20);
            chk(n >= (i[0] ? 11 : 19) && n <= (i[0] ? 13 : 21), 1'b1);
            wt(1, 1'b0);
            chk(20'((ta - t1) / 20), 20'h00004);
            er = exp_q.pop_front();
            u_host.rd(1'b1, 1'b0);
            #1 chk({res, oe_n[7:0]}, {er, 8'h00});
            u_host.rd(1'b0, 1'b0);
            #1 chk({res[11:4], oe_n}, {er[11:4], 12'h00F});
            u_host.rd(1'b0, 1'b1);
            #1 chk({res[7:0], oe_n}, {4'h0, er[3:0], 12'hF00});
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule
bind shcs_sequencer shcs_sva #(.CONV12_CYC(CONV12_CYC), .CONV8_CYC(CONV8_CYC)) u_sva (.*);
